/* rtl/rrc_map.vh */
`ifndef RRC_MAP_VH
`define RRC_MAP_VH

// ----------------------------------------------------------------
// state transition and calibration times in crystal cycles, ook minimum symbol count
// ----------------------------------------------------------------
`define RRC_IDLE_TO_RX_CYC 15'h07a1
`define RRC_RX_TO_IDLE_CYC 15'h0002
`define RRC_MAN_CAL_CYC 15'h011b
`define RRC_CAL_T09_NOPUMP 15'h0eb4
`define RRC_CAL_T0B_NOPUMP 15'h0fe9
`define RRC_CAL_T09_PUMP 15'h484a
`define RRC_CAL_T0B_PUMP 15'h497f
`define RRC_OOK_MIN_SYMBOLS 4'h8

// ----------------------------------------------------------------
// configuration codes
// ----------------------------------------------------------------
`define RRC_AUTOCAL_NONE 2'h0
`define RRC_AUTOCAL_TO_RX 2'h1
`define RRC_AUTOCAL_TO_IDLE 2'h2
`define RRC_AUTOCAL_FOURTH 2'h3
`define RRC_AFTER_RX 2'h3
`define RRC_TEST_LONG 8'h0b
`define RRC_PUMP_OFF 2'h0
`define RRC_PIN_THRESHOLD 6'h00

// ----------------------------------------------------------------
// fifo geometry and sync vector fields
// ----------------------------------------------------------------
`define RRC_FIFO_DEPTH 7'h40
`define RRC_CFG_W 26
`define RRC_CFG_AUTOCAL 1:0
`define RRC_CFG_AFTER 3:2
`define RRC_CFG_ABORT 4
`define RRC_CFG_OOK 5
`define RRC_CFG_THR 9:6
`define RRC_CFG_TEST 17:10
`define RRC_CFG_PUMP 19:18
`define RRC_CFG_PIN 25:20

`endif

/* rtl/rrc_top.v */
// Contract
// - receive starts from idle only on the enter-receive strobe
// - auto calibration: idle-to-rx, auto rx-to-idle, or every fourth auto exit
// - leaving receive by force-idle never calibrates
// - receive holds until good packet or carrier abort
// - after good packet go idle or restart search, per selector
// - force-idle strobe reaches idle from any state at once
// - abort option ends receive if first valid carrier sample is low
// - with on-off keying, carrier loss counts only after eight symbols
// - carrier abort always goes to idle, ignoring after-packet selector
// - idle to receive without calibration takes 1953 cycles
// - idle to receive with calibration adds calibration time
// - receive to idle takes 2 cycles, plus calibration when it runs
// - setting 0x09: calibration 3764 cycles pump off, 18506 pump on
// - setting 0x0B: calibration 4073 cycles pump off, 18815 pump on
// - 64-byte receive fifo read by host, overflow detected
// - fifo fill count readable as a status output
// - threshold bytes equal four times code plus four
// - threshold flag set while fill count at or above threshold
// - pin select 0x00 makes output pin follow threshold flag
`timescale 1ns/1ps
`include "rrc_map.vh"

module rrc_top #(
  parameter [14:0] CAL_T09_PUMP_CYC = `RRC_CAL_T09_PUMP,
  parameter [14:0] CAL_T0B_PUMP_CYC = `RRC_CAL_T0B_PUMP
) (
  input wire mclk,
  input wire rst,
  input wire enter_receive_strobe,
  input wire synth_calibrate_strobe,
  input wire force_idle_strobe,
  input wire fifo_flush_strobe,
  input wire link_clk,
  input wire host_rd_en,
  input wire [1:0] auto_calibration_select,
  input wire [1:0] after_packet_state_select,
  input wire carrier_missing_abort,
  input wire ook_mode,
  input wire [3:0] fifo_threshold_code,
  input wire [7:0] cal_test_setting,
  input wire [1:0] pump_current_cal_select,
  input wire [5:0] output_pin_select,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire pkt_ok,
  input wire cs_valid,
  input wire cs_above,
  input wire symbol_tick,
  output reg [4:0] radio_state_r,
  output reg search_restart_r,
  output reg [6:0] rx_fill_count_r,
  output reg fifo_overflow_r,
  output reg fifo_threshold_r,
  output reg general_output_pin_r,
  output reg [7:0] rd_data_r,
  output reg rd_valid_r
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CAL = 5'h02;
  localparam [4:0] ST_SETTLE = 5'h04;
  localparam [4:0] ST_RX = 5'h08;
  localparam [4:0] ST_OFF = 5'h10;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [`RRC_CFG_W-1:0] cfg_pin;
  reg [`RRC_CFG_W-1:0] cfg_s1_r;
  reg [`RRC_CFG_W-1:0] cfg_r;
  wire [5:0] ev_pin;
  reg [5:0] ev_s1_r;
  reg [5:0] ev_s2_r;
  reg [5:0] ev_s3_r;
  wire [5:0] ev_rise;

  assign cfg_pin = {output_pin_select, pump_current_cal_select, cal_test_setting,
                    fifo_threshold_code, ook_mode, carrier_missing_abort,
                    after_packet_state_select, auto_calibration_select};
  assign ev_pin = {host_rd_en, link_clk, fifo_flush_strobe, force_idle_strobe,
                   synth_calibrate_strobe, enter_receive_strobe};
  assign ev_rise = ev_s2_r & ~ev_s3_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_s1_r <= {`RRC_CFG_W{1'b0}};
      cfg_r <= {`RRC_CFG_W{1'b0}};
      ev_s1_r <= 6'h00;
      ev_s2_r <= 6'h00;
      ev_s3_r <= 6'h00;
    end else begin
      cfg_s1_r <= cfg_pin;
      cfg_r <= cfg_s1_r;
      ev_s1_r <= ev_pin;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  wire go_rx = ev_rise[0];
  wire go_cal = ev_rise[1];
  wire go_idle = ev_rise[2];
  wire flush = ev_rise[3];
  wire link_edge = ev_rise[4];
  wire rd_en = ev_s2_r[5];

  // ----------------------------------------------------------------
  // calibration length
  // ----------------------------------------------------------------
  reg [14:0] cal_len;
  always @* begin
    if (cfg_r[`RRC_CFG_TEST] == `RRC_TEST_LONG) begin
      if (cfg_r[`RRC_CFG_PUMP] == `RRC_PUMP_OFF)
        cal_len = `RRC_CAL_T0B_NOPUMP;
      else
        cal_len = CAL_T0B_PUMP_CYC;
    end else begin
      if (cfg_r[`RRC_CFG_PUMP] == `RRC_PUMP_OFF)
        cal_len = `RRC_CAL_T09_NOPUMP;
      else
        cal_len = CAL_T09_PUMP_CYC;
    end
  end

  // ----------------------------------------------------------------
  // radio controller
  // ----------------------------------------------------------------
  reg [14:0] cnt_r;
  reg cal_then_settle_r;
  reg cal_pending_r;
  reg [1:0] exit_cnt_r;
  reg cs_seen_r;
  reg [3:0] sym_cnt_r;
  wire [1:0] autocal = cfg_r[`RRC_CFG_AUTOCAL];
  wire cs_ok_time = ~cfg_r[`RRC_CFG_OOK] || (sym_cnt_r >= `RRC_OOK_MIN_SYMBOLS);
  wire cs_sample = cs_valid && cs_ok_time && ~cs_seen_r;
  wire cs_abort = cfg_r[`RRC_CFG_ABORT] && cs_sample && ~cs_above;
  wire auto_cal_exit = (autocal == `RRC_AUTOCAL_TO_IDLE) ||
                       ((autocal == `RRC_AUTOCAL_FOURTH) && (exit_cnt_r == 2'h3));

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      radio_state_r <= ST_IDLE;
      cnt_r <= 15'h0000;
      cal_then_settle_r <= 1'b0;
      cal_pending_r <= 1'b0;
      exit_cnt_r <= 2'h0;
      cs_seen_r <= 1'b0;
      sym_cnt_r <= 4'h0;
      search_restart_r <= 1'b0;
    end else begin
      search_restart_r <= 1'b0;
      if (go_idle) begin
        radio_state_r <= ST_IDLE;
        cal_pending_r <= 1'b0;
      end else begin
        case (radio_state_r)
          ST_IDLE: begin
            if (go_rx) begin
              if (autocal == `RRC_AUTOCAL_TO_RX) begin
                radio_state_r <= ST_CAL;
                cnt_r <= cal_len;
                cal_then_settle_r <= 1'b1;
              end else begin
                radio_state_r <= ST_SETTLE;
                cnt_r <= `RRC_IDLE_TO_RX_CYC;
              end
            end else if (go_cal) begin
              radio_state_r <= ST_CAL;
              cnt_r <= cal_len + `RRC_MAN_CAL_CYC;
              cal_then_settle_r <= 1'b0;
            end
          end
          ST_CAL: begin
            if (cnt_r <= 15'h0001) begin
              if (cal_then_settle_r) begin
                radio_state_r <= ST_SETTLE;
                cnt_r <= `RRC_IDLE_TO_RX_CYC;
              end else begin
                radio_state_r <= ST_IDLE;
              end
            end else begin
              cnt_r <= cnt_r - 15'h0001;
            end
          end
          ST_SETTLE: begin
            if (cnt_r <= 15'h0001) begin
              radio_state_r <= ST_RX;
              cs_seen_r <= 1'b0;
              sym_cnt_r <= 4'h0;
            end else begin
              cnt_r <= cnt_r - 15'h0001;
            end
          end
          ST_RX: begin
            if (symbol_tick && (sym_cnt_r != 4'hf))
              sym_cnt_r <= sym_cnt_r + 4'h1;
            if (cs_sample)
              cs_seen_r <= 1'b1;
            if (cs_abort || (pkt_ok && cfg_r[`RRC_CFG_AFTER] != `RRC_AFTER_RX)) begin
              radio_state_r <= ST_OFF;
              cnt_r <= `RRC_RX_TO_IDLE_CYC;
              cal_pending_r <= auto_cal_exit;
              exit_cnt_r <= exit_cnt_r + 2'h1;
            end else if (pkt_ok) begin
              search_restart_r <= 1'b1;
              cs_seen_r <= 1'b0;
              sym_cnt_r <= 4'h0;
            end
          end
          ST_OFF: begin
            if (cnt_r <= 15'h0001) begin
              cal_pending_r <= 1'b0;
              cal_then_settle_r <= 1'b0;
              if (cal_pending_r) begin
                radio_state_r <= ST_CAL;
                cnt_r <= cal_len;
              end else begin
                radio_state_r <= ST_IDLE;
              end
            end else begin
              cnt_r <= cnt_r - 15'h0001;
            end
          end
          default: begin
            radio_state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  reg [7:0] fifo_mem [0:63];
  reg [5:0] wr_ptr_r;
  reg [5:0] rd_ptr_r;
  wire full = (rx_fill_count_r == `RRC_FIFO_DEPTH);
  wire wr_try = rx_byte_valid && (radio_state_r == ST_RX);
  wire do_wr = wr_try && ~full && ~flush;
  // an empty pop is ignored; the host is expected never to read past empty
  wire do_rd = link_edge && rd_en && (rx_fill_count_r != 7'h00) && ~flush;
  wire [6:0] thr_bytes = {1'b0, cfg_r[`RRC_CFG_THR], 2'h0} + 7'h04;
  reg [6:0] count_nxt;

  always @* begin
    count_nxt = rx_fill_count_r;
    if (flush)
      count_nxt = 7'h00;
    else if (do_wr && ~do_rd)
      count_nxt = rx_fill_count_r + 7'h01;
    else if (do_rd && ~do_wr)
      count_nxt = rx_fill_count_r - 7'h01;
  end

  always @(posedge mclk) begin
    if (do_wr)
      fifo_mem[wr_ptr_r] <= rx_byte;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= 6'h00;
      rd_ptr_r <= 6'h00;
      rx_fill_count_r <= 7'h00;
      fifo_overflow_r <= 1'b0;
      fifo_threshold_r <= 1'b0;
      general_output_pin_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= do_rd;
      if (flush) begin
        wr_ptr_r <= 6'h00;
        rd_ptr_r <= 6'h00;
      end else begin
        if (do_wr)
          wr_ptr_r <= wr_ptr_r + 6'h01;
        if (do_rd) begin
          rd_ptr_r <= rd_ptr_r + 6'h01;
          rd_data_r <= fifo_mem[rd_ptr_r];
        end
      end
      rx_fill_count_r <= count_nxt;
      if (wr_try && full)
        fifo_overflow_r <= 1'b1;
      else if (flush)
        fifo_overflow_r <= 1'b0;
      fifo_threshold_r <= (count_nxt >= thr_bytes);
      general_output_pin_r <= (cfg_r[`RRC_CFG_PIN] == `RRC_PIN_THRESHOLD) &&
                              (count_nxt >= thr_bytes);
    end
  end

endmodule // rrc_top

/* dv/rrc_top_props.sv */
`timescale 1ns/1ps
module rrc_top_props #(
  parameter [14:0] CAL_T09_PUMP_CYC = 15'h484a,
  parameter [14:0] CAL_T0B_PUMP_CYC = 15'h497f
) (
  input wire mclk,
  input wire rst,
  input wire force_idle_strobe,
  input wire [1:0] after_packet_state_select,
  input wire carrier_missing_abort,
  input wire ook_mode,
  input wire [3:0] fifo_threshold_code,
  input wire [7:0] cal_test_setting,
  input wire [1:0] pump_current_cal_select,
  input wire [5:0] output_pin_select,
  input wire rx_byte_valid,
  input wire pkt_ok,
  input wire cs_valid,
  input wire cs_above,
  input wire [4:0] radio_state_r,
  input wire search_restart_r,
  input wire [6:0] rx_fill_count_r,
  input wire fifo_overflow_r,
  input wire fifo_threshold_r,
  input wire general_output_pin_r,
  input wire rd_valid_r
);
  // ----------------------------------------------------------------
  // dwell time of the previous state
  // ----------------------------------------------------------------
  reg [4:0] prev_r;
  reg [15:0] dwell_r;
  wire [15:0] cal_len = (cal_test_setting == 8'h0b) ?
    ((pump_current_cal_select == 2'h0) ? 16'h0fe9 : {1'b0, CAL_T0B_PUMP_CYC}) :
    ((pump_current_cal_select == 2'h0) ? 16'h0eb4 : {1'b0, CAL_T09_PUMP_CYC});
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_r <= 5'h01;
      dwell_r <= 16'h0001;
    end else begin
      prev_r <= radio_state_r;
      dwell_r <= (radio_state_r == prev_r) ? dwell_r + 16'h0001 : 16'h0001;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence left_s(st);
    prev_r == st && radio_state_r != st;
  endsequence
  settle_len_a: assert property (left_s(5'h04) ##0 radio_state_r == 5'h08
    |-> dwell_r == 16'h07a1) else $error("settle length wrong");
  off_len_a: assert property (left_s(5'h10) |-> dwell_r == 16'h0002)
    else $error("rx exit length wrong");
  cal_len_a: assert property (left_s(5'h02) |->
    dwell_r == cal_len || dwell_r == cal_len + 16'h011b) else $error("cal length wrong");
  rx_entry_a: assert property ($rose(radio_state_r == 5'h08) |-> prev_r == 5'h04)
    else $error("receive entered without settle");
  force_idle_a: assert property ($rose(force_idle_strobe) |->
    ##[3:6] radio_state_r == 5'h01) else $error("force idle missed");
  overflow_set_a: assert property (rx_byte_valid && radio_state_r == 5'h08 &&
    rx_fill_count_r == 7'h40 |=> fifo_overflow_r && rx_fill_count_r == 7'h40)
    else $error("overflow not flagged");
  thr_level_a: assert property (fifo_threshold_code == $past(fifo_threshold_code, 3)
    |-> fifo_threshold_r == (rx_fill_count_r >= {1'b0, fifo_threshold_code, 2'b00} + 7'h04))
    else $error("threshold flag wrong");
  pin_follow_a: assert property (output_pin_select == 6'h00 &&
    $past(output_pin_select, 3) == 6'h00 |->
    general_output_pin_r == fifo_threshold_r) else $error("pin not following threshold");
  restart_rx_a: assert property (pkt_ok && radio_state_r == 5'h08 &&
    after_packet_state_select == 2'h3 |=> search_restart_r && radio_state_r == 5'h08)
    else $error("search restart missing");
  abort_idle_a: assert property (cs_valid && !cs_above && carrier_missing_abort &&
    !ook_mode && radio_state_r == 5'h08 |=> radio_state_r == 5'h10) else $error("abort missed");
  pop_count_a: assert property (rd_valid_r && !$past(rx_byte_valid) |->
    rx_fill_count_r == $past(rx_fill_count_r) - 7'h01) else $error("pop count wrong");
endmodule // rrc_top_props

bind rrc_top rrc_top_props #(.CAL_T09_PUMP_CYC(CAL_T09_PUMP_CYC),
  .CAL_T0B_PUMP_CYC(CAL_T0B_PUMP_CYC)) rrc_top_props_i (.*);

/* dv/rrc_host_model.sv */
`timescale 1ns/1ps
module rrc_host_model (
  input wire go,
  input wire [6:0] n_rd,
  input wire [6:0] fill,
  output reg link_clk,
  output reg host_rd_en,
  output reg busy
);
  integer k;
  integer lim;
  integer n0;
  // ----------------------------------------------------------------
  // serial reads, clock still between frames
  // ----------------------------------------------------------------
  initial begin
    link_clk = 1'b0;
    host_rd_en = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      host_rd_en = 1'b1;
      // poll the fill count until two reads agree, then read n_rd bytes, at most one fewer than the fill count
      n0 = fill;
      #80;
      while (fill != n0) begin
        n0 = fill;
        #80;
      end
      lim = (n_rd < n0) ? n_rd : n0 - 1;
      #23;
      for (k = 0; k < lim; k = k + 1) begin
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end
      #80 host_rd_en = 1'b0;
      busy = 1'b0;
    end
  end
endmodule // rrc_host_model

/* dv/rrc_top_test.sv */
`timescale 1ns/1ps
module rrc_top_test;
  reg mclk, rst, rbv, go, abort, ook;
  reg [3:0] strb, thr;
  reg [2:0] ev;
  reg [1:0] asel, aft;
  reg [7:0] rbyte, last_rd;
  reg [7:0] tset;
  reg [5:0] psel;
  reg [6:0] n_rd;
  reg [11:0] rows [0:5];
  wire [4:0] st;
  wire [6:0] cnt;
  wire lck, ren, busy, rst_pulse, ovf, thf, pin, rdv;
  wire [7:0] rdd;
  integer num_errors, check_count, k;
  rrc_top #(.CAL_T09_PUMP_CYC(15'h0028), .CAL_T0B_PUMP_CYC(15'h0032)) rrc_top_i (
    .mclk(mclk), .rst(rst), .enter_receive_strobe(strb[0]), .synth_calibrate_strobe(strb[1]),
    .force_idle_strobe(strb[2]), .fifo_flush_strobe(strb[3]), .link_clk(lck),
    .host_rd_en(ren), .auto_calibration_select(asel), .after_packet_state_select(aft),
    .carrier_missing_abort(abort), .ook_mode(ook), .fifo_threshold_code(thr),
    .cal_test_setting(tset), .pump_current_cal_select(2'h2), .output_pin_select(psel),
    .rx_byte_valid(rbv), .rx_byte(rbyte), .pkt_ok(ev[2]), .cs_valid(ev[1]), .cs_above(1'b0),
    .symbol_tick(ev[0]), .radio_state_r(st), .search_restart_r(rst_pulse),
    .rx_fill_count_r(cnt), .fifo_overflow_r(ovf), .fifo_threshold_r(thf),
    .general_output_pin_r(pin), .rd_data_r(rdd), .rd_valid_r(rdv));
  rrc_host_model rrc_host_model_i (.go(go), .n_rd(n_rd), .fill(cnt), .link_clk(lck),
    .host_rd_en(ren), .busy(busy));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input [7:0] exp, input [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      num_errors = num_errors + 1;
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task pulse(input [3:0] m);
    @(posedge mclk) strb <= m;
    repeat (3) @(posedge mclk);
    strb <= 4'h0;
    repeat (6) @(posedge mclk);
  endtask
  task evp(input [2:0] m);
    @(posedge mclk) ev <= m;
    @(posedge mclk) ev <= 3'h0;
  endtask
  task wait_st(input [4:0] s);
    integer n;
    n = 0;
    while (st !== s && n < 30000) begin
      @(posedge mclk);
      n = n + 1;
    end
  endtask
  task wr(input [6:0] n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(posedge mclk) rbv <= 1'b1;
      rbyte <= i[7:0];
    end
    @(posedge mclk) rbv <= 1'b0;
    @(posedge mclk);
  endtask
  always @(posedge mclk) if (rdv) last_rd <= rdd;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #400000;
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial begin
    {rst, rbv, go, abort, ook, strb, thr, ev, aft, rbyte, n_rd} = 0;
    rst = 1'b1;
    asel = 2'h3;
    tset = 8'h0b;
    psel = 6'h00;
    num_errors = 0;
    check_count = 0;
    rows[0] = 12'h003; rows[1] = 12'h084; rows[2] = 12'hd37;
    rows[3] = 12'hdb8; rows[4] = 12'hf3f; rows[5] = 12'hfc0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("state", 8'h01, {3'h0, st});
    for (k = 1; k <= 4; k = k + 1) begin
      pulse(4'h1);
      wait_st(5'h08);
      evp(3'h4);
      repeat (5) @(posedge mclk);
      chk("fourth cal", {7'h0, k == 4}, {7'h0, st == 5'h02});
      wait_st(5'h01);
    end
    asel <= 2'h0;
    aft <= 2'h3;
    pulse(4'h1);
    wait_st(5'h08);
    for (k = 0; k < 6; k = k + 1) begin
      pulse(4'h8);
      thr <= rows[k][11:8];
      repeat (4) @(posedge mclk);
      wr(rows[k][6:0]);
      chk("count", {1'b0, rows[k][6:0]}, {1'b0, cnt});
      chk("thresh", {7'h0, rows[k][7]}, {7'h0, thf});
      chk("pin", {7'h0, rows[k][7]}, {7'h0, pin});
    end
    wr(7'h01);
    chk("overflow", 8'h01, {7'h0, ovf});
    psel <= 6'h01;
    repeat (4) @(posedge mclk);
    chk("pin off", 8'h00, {7'h0, pin});
    psel <= 6'h00;
    n_rd <= 7'h02;
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    for (k = 0; k < 400 && busy; k = k + 1) @(posedge mclk);
    repeat (8) @(posedge mclk);
    chk("rd data", 8'h01, last_rd);
    chk("count", 8'h3e, {1'b0, cnt});
    chk("pin", 8'h00, {7'h0, pin});
    evp(3'h4);
    repeat (2) @(posedge mclk);
    chk("state", 8'h08, {3'h0, st});
    ook <= 1'b1;
    abort <= 1'b1;
    repeat (4) @(posedge mclk);
    evp(3'h2);
    repeat (4) @(posedge mclk);
    chk("state", 8'h08, {3'h0, st});
    for (k = 0; k < 8; k = k + 1) evp(3'h1);
    evp(3'h2);
    repeat (6) @(posedge mclk);
    chk("state", 8'h01, {3'h0, st});
    ook <= 1'b0;
    pulse(4'h1);
    wait_st(5'h08);
    evp(3'h2);
    repeat (6) @(posedge mclk);
    chk("state", 8'h01, {3'h0, st});
    asel <= 2'h2;
    abort <= 1'b0;
    pulse(4'h1);
    wait_st(5'h08);
    pulse(4'h4);
    repeat (8) @(posedge mclk);
    chk("state", 8'h01, {3'h0, st});
    tset <= 8'h09;
    pulse(4'h2);
    chk("state", 8'h02, {3'h0, st});
    repeat (300) @(posedge mclk);
    chk("cal 09", 8'h02, {3'h0, st});
    repeat (24) @(posedge mclk);
    chk("cal 09 end", 8'h01, {3'h0, st});
    wait_st(5'h01);
    print_verdict;
  end
endmodule // rrc_top_test
